// >>> rtl/long_ops_pkg.sv
// Constants for the long-addressed move, OR and rotate datapath.
// Assumes a single core clock and an active-low asynchronous core reset.
package long_ops_pkg;
    // ==========================================================
    // Widths, reset values and bit positions
    localparam int DATA_W = 8;
    localparam int ADDR_W = 16;
    localparam logic [7:0] WORKING_RESET = 8'h00;
    localparam logic ZERO_RESET = 1'b0;
    localparam logic LINK_RESET = 1'b0;
    localparam int TOP_BIT = 7;
    localparam int BOTTOM_BIT = 0;

    // ==========================================================
    // Operation codes
    typedef enum logic [3:0] {
        OP_COPY_TO_WORKING = 4'h0,
        OP_COPY_TO_MEMORY = 4'h1,
        OP_OR_TO_WORKING = 4'h2,
        OP_OR_TO_MEMORY = 4'h3,
        OP_ROL_PLAIN = 4'h4,
        OP_ROL_PLAIN_TO_WORKING = 4'h5,
        OP_ROL_LINK = 4'h6,
        OP_ROL_LINK_TO_WORKING = 4'h7,
        OP_ROR_PLAIN = 4'h8,
        OP_ROR_PLAIN_TO_WORKING = 4'h9,
        OP_ROR_LINK = 4'ha
    } long_op_t;
endpackage

// >>> rtl/long_result_unit.sv
// Combinational result unit: computes the byte and flag results of one op.
// Assumes operands are stable for the cycle in which the op is issued.
`timescale 1ns/1ns
module long_result_unit
    import long_ops_pkg::*;
(
    input wire long_op_t i_op,           // Operation code
    input wire logic [7:0] i_working,    // Current working register
    input wire logic [7:0] i_mem,        // Addressed memory byte
    input wire logic i_link,             // Current link (carry) flag
    output logic [7:0] o_result,         // Byte result
    output logic o_link_new,             // Link value when link is written
    output logic o_writes_working,       // Result goes to working register
    output logic o_writes_memory,        // Result goes to memory
    output logic o_writes_zero,          // Zero flag is updated
    output logic o_writes_link           // Link flag is updated
);
    // ==========================================================
    // Shared operand forms
    wire [7:0] or_val = i_working | i_mem;
    wire [7:0] rol_plain = {i_mem[6:0], i_mem[TOP_BIT]};
    wire [7:0] rol_link = {i_mem[6:0], i_link};
    wire [7:0] ror_plain = {i_mem[BOTTOM_BIT], i_mem[7:1]};
    wire [7:0] ror_link = {i_link, i_mem[7:1]};

    // Selection of result and destinations by op
    always_comb begin
        o_result = 8'h00;
        o_link_new = i_link;
        o_writes_working = 1'b0;
        o_writes_memory = 1'b0;
        o_writes_zero = 1'b0;
        o_writes_link = 1'b0;
        case (i_op)
            OP_COPY_TO_WORKING: begin
                o_result = i_mem;
                o_writes_working = 1'b1;
            end
            OP_COPY_TO_MEMORY: begin
                o_result = i_working;
                o_writes_memory = 1'b1;
            end
            OP_OR_TO_WORKING: begin
                o_result = or_val;
                o_writes_working = 1'b1;
                o_writes_zero = 1'b1;
            end
            OP_OR_TO_MEMORY: begin
                o_result = or_val;
                o_writes_memory = 1'b1;
                o_writes_zero = 1'b1;
            end
            OP_ROL_PLAIN: begin
                o_result = rol_plain;
                o_writes_memory = 1'b1;
            end
            OP_ROL_PLAIN_TO_WORKING: begin
                o_result = rol_plain;
                o_writes_working = 1'b1;
            end
            OP_ROL_LINK: begin
                o_result = rol_link;
                o_link_new = i_mem[TOP_BIT];
                o_writes_memory = 1'b1;
                o_writes_link = 1'b1;
            end
            OP_ROL_LINK_TO_WORKING: begin
                o_result = rol_link;
                o_link_new = i_mem[TOP_BIT];
                o_writes_working = 1'b1;
                o_writes_link = 1'b1;
            end
            OP_ROR_PLAIN: begin
                o_result = ror_plain;
                o_writes_memory = 1'b1;
            end
            OP_ROR_PLAIN_TO_WORKING: begin
                o_result = ror_plain;
                o_writes_working = 1'b1;
            end
            OP_ROR_LINK: begin
                o_result = ror_link;
                o_link_new = i_mem[BOTTOM_BIT];
                o_writes_memory = 1'b1;
                o_writes_link = 1'b1;
            end
            default: begin
                o_result = 8'h00; // Unknown codes do nothing
            end
        endcase
    end
endmodule

// >>> rtl/long_addr_move_or_rotate.sv
// Execution datapath for long-addressed move, OR and rotate operations.
// Assumes the core supplies the addressed memory byte in the issue cycle and
// accepts a one-cycle write strobe with address and data from flip-flops.
`timescale 1ns/1ns
module long_addr_move_or_rotate
    import long_ops_pkg::*;
(
    input wire logic i_mclk,                 // Core clock, 20 MHz
    input wire logic i_rst_n,                // Async reset, active low
    input wire logic i_valid,                // Issue strobe, one op per cycle
    input wire long_op_t i_op,               // Operation code
    input wire logic [ADDR_W-1:0] i_addr,    // Data memory address of operand
    input wire logic [7:0] i_mem_rdata,      // Addressed memory byte
    output logic o_mem_we,                   // Memory write strobe, one cycle
    output logic [ADDR_W-1:0] o_mem_addr,    // Memory write address
    output logic [7:0] o_mem_wdata,          // Memory write data
    output logic [7:0] o_working,            // Working register
    output logic o_zero,                     // Zero flag
    output logic o_link                      // Link (carry) flag
);
    // ==========================================================
    // Result computation
    logic [7:0] result;
    logic link_new;
    logic wr_working;
    logic wr_memory;
    logic wr_zero;
    logic wr_link;

    long_result_unit u_result (
        .i_op(i_op),
        .i_working(o_working),
        .i_mem(i_mem_rdata),
        .i_link(o_link),
        .o_result(result),
        .o_link_new(link_new),
        .o_writes_working(wr_working),
        .o_writes_memory(wr_memory),
        .o_writes_zero(wr_zero),
        .o_writes_link(wr_link)
    );

    // ==========================================================
    // Qualified update enables
    wire do_working = i_valid & wr_working;
    wire do_memory = i_valid & wr_memory;
    wire do_zero = i_valid & wr_zero;
    wire do_link = i_valid & wr_link;
    wire zero_val = (result == 8'h00);

    // Working register; memory writes take effect in the core's memory next cycle
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_working <= WORKING_RESET;
        end else if (do_working) begin
            o_working <= result;
        end
    end

    // Flags hold unless the op names them, so unlisted flags are untouched
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_zero <= ZERO_RESET;
            o_link <= LINK_RESET;
        end else begin
            if (do_zero) begin
                o_zero <= zero_val;
            end
            if (do_link) begin
                o_link <= link_new;
            end
        end
    end

    // Registered write port; strobe lasts exactly one cycle per op
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_mem_we <= 1'b0;
            o_mem_addr <= '0;
            o_mem_wdata <= 8'h00;
        end else begin
            o_mem_we <= do_memory;
            if (do_memory) begin
                o_mem_addr <= i_addr;
                o_mem_wdata <= result;
            end
        end
    end

    // ==========================================================
    // Checks
    // Op groups come straight from the codes, so the checks do not lean on the result unit
    wire op_is_or = (i_op == OP_OR_TO_WORKING) || (i_op == OP_OR_TO_MEMORY);
    wire op_is_link = (i_op == OP_ROL_LINK) || (i_op == OP_ROL_LINK_TO_WORKING) || (i_op == OP_ROR_LINK);
    wire op_to_memory = (i_op == OP_COPY_TO_MEMORY) || (i_op == OP_OR_TO_MEMORY) || (i_op == OP_ROL_PLAIN)
        || (i_op == OP_ROL_LINK) || (i_op == OP_ROR_PLAIN) || (i_op == OP_ROR_LINK);
    wire op_to_working = (i_op == OP_COPY_TO_WORKING) || (i_op == OP_OR_TO_WORKING)
        || (i_op == OP_ROL_PLAIN_TO_WORKING) || (i_op == OP_ROL_LINK_TO_WORKING)
        || (i_op == OP_ROR_PLAIN_TO_WORKING);
    wire op_known = op_to_memory | op_to_working;
    wire op_rotate_left_link = (i_op == OP_ROL_LINK) || (i_op == OP_ROL_LINK_TO_WORKING);
    wire op_plain_rotate = (i_op == OP_ROL_PLAIN) || (i_op == OP_ROL_PLAIN_TO_WORKING) || (i_op == OP_ROR_PLAIN)
        || (i_op == OP_ROR_PLAIN_TO_WORKING);
    wire op_copy = (i_op == OP_COPY_TO_WORKING) || (i_op == OP_COPY_TO_MEMORY);

    // Issue steps named once and shared by the checks below
    sequence s_issue_or;
        i_valid && op_is_or;
    endsequence
    sequence s_issue_not_or;
        i_valid && !op_is_or;
    endsequence
    sequence s_issue_not_link;
        i_valid && !op_is_link;
    endsequence
    sequence s_issue_memory;
        i_valid && op_to_memory;
    endsequence
    sequence s_issue_working;
        i_valid && op_to_working;
    endsequence
    sequence s_issue_unknown;
        i_valid && !op_known;
    endsequence
    sequence s_issue_left_link;
        i_valid && op_rotate_left_link;
    endsequence
    sequence s_issue_plain_rotate;
        i_valid && op_plain_rotate;
    endsequence
    sequence s_issue_copy;
        i_valid && op_copy;
    endsequence
    sequence s_pause;
        !i_valid;
    endsequence

    property p_copy_working;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (i_valid && i_op == OP_COPY_TO_WORKING) |=>
            (o_working == $past(i_mem_rdata)) && !o_mem_we && $stable(o_zero) && $stable(o_link);
    endproperty
    a_copy_working: assert property (p_copy_working) else $error("copy to working wrong");

    property p_copy_memory;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (i_valid && i_op == OP_COPY_TO_MEMORY) |=>
            o_mem_we && (o_mem_wdata == $past(o_working)) && (o_mem_addr == $past(i_addr)) && $stable(o_link);
    endproperty
    a_copy_memory: assert property (p_copy_memory) else $error("copy to memory wrong");

    property p_or_working;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (i_valid && i_op == OP_OR_TO_WORKING) |=>
            (o_working == ($past(o_working) | $past(i_mem_rdata))) && (o_zero == (o_working == 8'h00))
            && $stable(o_link);
    endproperty
    a_or_working: assert property (p_or_working) else $error("or to working wrong");

    property p_or_memory;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (i_valid && i_op == OP_OR_TO_MEMORY) |=>
            o_mem_we && (o_mem_wdata == ($past(o_working) | $past(i_mem_rdata)))
            && (o_zero == (o_mem_wdata == 8'h00)) && $stable(o_working);
    endproperty
    a_or_memory: assert property (p_or_memory) else $error("or to memory wrong");

    property p_rol_plain;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (i_valid && i_op == OP_ROL_PLAIN) |=>
            o_mem_we && (o_mem_wdata == {$past(i_mem_rdata[6:0]), $past(i_mem_rdata[7])}) && $stable(o_link);
    endproperty
    a_rol_plain: assert property (p_rol_plain) else $error("plain left rotate wrong");

    property p_rol_plain_working;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (i_valid && i_op == OP_ROL_PLAIN_TO_WORKING) |=>
            !o_mem_we && (o_working == {$past(i_mem_rdata[6:0]), $past(i_mem_rdata[7])});
    endproperty
    a_rol_plain_working: assert property (p_rol_plain_working) else $error("left rotate to working wrong");

    property p_rol_link;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (i_valid && i_op == OP_ROL_LINK) |=>
            o_mem_we && (o_mem_wdata == {$past(i_mem_rdata[6:0]), $past(o_link)})
            && (o_link == $past(i_mem_rdata[7]));
    endproperty
    a_rol_link: assert property (p_rol_link) else $error("left rotate through link wrong");

    property p_rol_link_working;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (i_valid && i_op == OP_ROL_LINK_TO_WORKING) |=>
            !o_mem_we && (o_working == {$past(i_mem_rdata[6:0]), $past(o_link)})
            && (o_link == $past(i_mem_rdata[7]));
    endproperty
    a_rol_link_working: assert property (p_rol_link_working) else $error("left link rotate to working wrong");

    property p_ror_plain;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (i_valid && i_op == OP_ROR_PLAIN) |=>
            o_mem_we && (o_mem_wdata == {$past(i_mem_rdata[0]), $past(i_mem_rdata[7:1])}) && $stable(o_zero);
    endproperty
    a_ror_plain: assert property (p_ror_plain) else $error("plain right rotate wrong");

    property p_ror_plain_working;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (i_valid && i_op == OP_ROR_PLAIN_TO_WORKING) |=>
            !o_mem_we && (o_working == {$past(i_mem_rdata[0]), $past(i_mem_rdata[7:1])}) && $stable(o_link);
    endproperty
    a_ror_plain_working: assert property (p_ror_plain_working) else $error("right rotate to working wrong");

    property p_ror_link;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (i_valid && i_op == OP_ROR_LINK) |=>
            o_mem_we && (o_mem_wdata == {$past(o_link), $past(i_mem_rdata[7:1])})
            && (o_link == $past(i_mem_rdata[0])) && $stable(o_working);
    endproperty
    a_ror_link: assert property (p_ror_link) else $error("right rotate through link wrong");

    property p_flags_hold;
        @(posedge i_mclk) disable iff (!i_rst_n)
        !i_valid |=> $stable(o_zero) && $stable(o_link) && $stable(o_working) && !o_mem_we;
    endproperty
    a_flags_hold: assert property (p_flags_hold) else $error("state changed while idle");

    // ==========================================================
    // Checks across op groups
    // Each but the write port hold check, keyed on the strobe, watches the outputs that a whole group must touch or leave alone
    property p_zero_tracks_or;
        @(posedge i_mclk) disable iff (!i_rst_n)
        s_issue_or |=> (o_zero == ($past(o_working | i_mem_rdata) == 8'h00));
    endproperty
    a_zero_tracks_or: assert property (p_zero_tracks_or) else $error("zero flag does not follow or result");

    property p_zero_kept;
        @(posedge i_mclk) disable iff (!i_rst_n)
        s_issue_not_or |=> $stable(o_zero);
    endproperty
    a_zero_kept: assert property (p_zero_kept) else $error("zero flag moved on a non-or op");

    property p_link_kept;
        @(posedge i_mclk) disable iff (!i_rst_n)
        s_issue_not_link |=> $stable(o_link);
    endproperty
    a_link_kept: assert property (p_link_kept) else $error("link flag moved on a non-link op");

    property p_memory_ops_write;
        @(posedge i_mclk) disable iff (!i_rst_n)
        s_issue_memory |=> o_mem_we && (o_mem_addr == $past(i_addr)) && $stable(o_working);
    endproperty
    a_memory_ops_write: assert property (p_memory_ops_write) else $error("memory op wrote wrongly");

    property p_working_ops_no_write;
        @(posedge i_mclk) disable iff (!i_rst_n)
        s_issue_working |=> !o_mem_we;
    endproperty
    a_working_ops_no_write: assert property (p_working_ops_no_write) else $error("working op wrote memory");

    property p_working_ops_keep_port;
        @(posedge i_mclk) disable iff (!i_rst_n)
        s_issue_working |=> $stable(o_mem_addr) && $stable(o_mem_wdata);
    endproperty
    a_working_ops_keep_port: assert property (p_working_ops_keep_port) else $error("working op moved write port");

    property p_unknown_no_effect;
        @(posedge i_mclk) disable iff (!i_rst_n)
        s_issue_unknown |=> !o_mem_we && $stable(o_working) && $stable(o_zero) && $stable(o_link);
    endproperty
    a_unknown_no_effect: assert property (p_unknown_no_effect) else $error("unknown code had an effect");

    // The strobe is a single pulse: a pause after a write drops it and freezes address and data
    property p_strobe_single;
        @(posedge i_mclk) disable iff (!i_rst_n)
        s_issue_memory ##1 s_pause |=> !o_mem_we && $stable(o_mem_addr) && $stable(o_mem_wdata);
    endproperty
    a_strobe_single: assert property (p_strobe_single) else $error("write strobe not a single pulse");

    // Address and data move only with the strobe, so the core may latch them late
    property p_write_port_holds;
        @(posedge i_mclk) disable iff (!i_rst_n)
        !o_mem_we |-> $stable(o_mem_addr) && $stable(o_mem_wdata);
    endproperty
    a_write_port_holds: assert property (p_write_port_holds) else $error("write port moved without strobe");

    property p_left_link_source;
        @(posedge i_mclk) disable iff (!i_rst_n)
        s_issue_left_link |=> (o_link == $past(i_mem_rdata[TOP_BIT]));
    endproperty
    a_left_link_source: assert property (p_left_link_source) else $error("link not loaded from top bit");

    property p_plain_rotate_flags;
        @(posedge i_mclk) disable iff (!i_rst_n)
        s_issue_plain_rotate |=> $stable(o_zero) && $stable(o_link);
    endproperty
    a_plain_rotate_flags: assert property (p_plain_rotate_flags) else $error("plain rotate changed a flag");

    property p_copy_flags;
        @(posedge i_mclk) disable iff (!i_rst_n)
        s_issue_copy |=> $stable(o_zero) && $stable(o_link);
    endproperty
    a_copy_flags: assert property (p_copy_flags) else $error("copy changed a flag");
endmodule

// >>> bench/tb.sv
// Self-checking bench for the long-addressed move, OR and rotate datapath.
// Assumes the bench stands in for the core: it supplies the operand byte and watches the write strobe.
`timescale 1ns/1ns
module tb;
    import long_ops_pkg::*;
    // ==========================================================
    // Stimulus, outputs and bench state
    logic i_mclk = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_valid = 1'b0;
    long_op_t i_op = OP_COPY_TO_WORKING;
    logic [ADDR_W-1:0] i_addr = 16'h0000;
    logic [7:0] i_mem_rdata = 8'h00;
    wire logic o_mem_we;
    wire logic [ADDR_W-1:0] o_mem_addr;
    wire logic [7:0] o_mem_wdata;
    wire logic [7:0] o_working;
    wire logic o_zero;
    wire logic o_link;
    int failures = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [7:0] w = 8'h00;
    logic z = 1'b0;
    logic l = 1'b0;

    long_addr_move_or_rotate long_addr_move_or_rotate_i (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_valid(i_valid),
        .i_op(i_op), .i_addr(i_addr), .i_mem_rdata(i_mem_rdata), .o_mem_we(o_mem_we), .o_mem_addr(o_mem_addr),
        .o_mem_wdata(o_mem_wdata), .o_working(o_working), .o_zero(o_zero), .o_link(o_link));

    // ==========================================================
    // Clock and hang guard; a full run needs well under 100 cycles
    always #25 i_mclk = ~i_mclk;
    always @(posedge i_mclk) begin
        cycles++;
        if (cycles == 2000) begin
            failures++;
            give_verdict();
        end
    end

    // ==========================================================
    // Shared helpers
    function automatic logic [7:0] rol(input logic [7:0] m, input logic b);
        return {m[6:0], b};
    endfunction
    function automatic logic [7:0] ror(input logic [7:0] m, input logic b);
        return {b, m[7:1]};
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: %s is %h, expected %h", $time, what, got, exp);
        end
    endtask

    // Issue one op at a falling edge, judge the answer at the next falling edge; valid stays up so ops run back to back
    task automatic run_op(input long_op_t op, input logic [15:0] a, input logic [7:0] m, input logic we,
                          input logic [7:0] nw, input logic nz, input logic nl, input logic [7:0] wd);
        i_valid = 1'b1;
        i_op = op;
        i_addr = a;
        i_mem_rdata = m;
        @(posedge i_mclk);
        @(negedge i_mclk);
        chk(o_mem_we, we, "write strobe");
        if (we) begin
            chk(o_mem_addr, a, "write address");
            chk(o_mem_wdata, wd, "write data");
        end
        chk(o_working, nw, "working register");
        chk(o_zero, nz, "zero flag");
        chk(o_link, nl, "link flag");
        w = nw;
        z = nz;
        l = nl;
    endtask

    // Drop valid for a cycle; the strobe must be gone and the working register and flags may not move
    task automatic go_idle;
        i_valid = 1'b0;
        @(posedge i_mclk);
        @(negedge i_mclk);
        chk(o_mem_we, 1'b0, "idle strobe");
        chk({o_working, o_zero, o_link}, {w, z, l}, "idle state");
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_or;
        run_op(OP_OR_TO_WORKING, 16'h0001, 8'h00, 1'b0, w | 8'h00, (w | 8'h00) == 8'h00, l, 8'h00);
        run_op(OP_OR_TO_MEMORY, 16'h8001, 8'h00, 1'b1, w, (w | 8'h00) == 8'h00, l, w | 8'h00);
        run_op(OP_OR_TO_WORKING, 16'h0002, 8'h81, 1'b0, w | 8'h81, (w | 8'h81) == 8'h00, l, 8'h00);
        run_op(OP_OR_TO_MEMORY, 16'hffff, 8'h10, 1'b1, w, (w | 8'h10) == 8'h00, l, w | 8'h10);
        go_idle();
    endtask

    task automatic t_rol;
        run_op(OP_ROL_PLAIN, 16'h0102, 8'h81, 1'b1, w, z, l, rol(8'h81, 1'b1));
        run_op(OP_ROL_PLAIN_TO_WORKING, 16'h0103, 8'h80, 1'b0, rol(8'h80, 1'b1), z, l, 8'h00);
        run_op(OP_ROL_LINK, 16'h0104, 8'h80, 1'b1, w, z, 1'b1, rol(8'h80, l));
        run_op(OP_ROL_LINK_TO_WORKING, 16'h0105, 8'h01, 1'b0, rol(8'h01, l), z, 1'b0, 8'h00);
        go_idle();
    endtask

    task automatic t_ror;
        run_op(OP_ROR_PLAIN, 16'h2000, 8'h01, 1'b1, w, z, l, ror(8'h01, 1'b1));
        run_op(OP_ROR_PLAIN_TO_WORKING, 16'h2001, 8'h02, 1'b0, ror(8'h02, 1'b0), z, l, 8'h00);
        run_op(OP_ROR_LINK, 16'h2002, 8'h01, 1'b1, w, z, 1'b1, ror(8'h01, l));
        run_op(OP_ROR_LINK, 16'h2003, 8'h00, 1'b1, w, z, 1'b0, ror(8'h00, l));
        go_idle();
    endtask

    // Both flags are set early on, so a copy, a rotate or an unknown code that disturbs them shows up
    task automatic t_flags_kept;
        run_op(OP_COPY_TO_WORKING, 16'h0010, 8'h00, 1'b0, 8'h00, z, l, 8'h00);
        run_op(OP_ROL_LINK, 16'h0011, 8'h80, 1'b1, w, z, 1'b1, rol(8'h80, l));
        run_op(OP_OR_TO_WORKING, 16'h0012, 8'h00, 1'b0, w, 1'b1, l, 8'h00);
        run_op(OP_COPY_TO_WORKING, 16'h0013, 8'ha5, 1'b0, 8'ha5, z, l, 8'h00);
        run_op(OP_COPY_TO_MEMORY, 16'hfffe, 8'h3c, 1'b1, w, z, l, w);
        run_op(OP_ROR_PLAIN, 16'h0014, 8'h02, 1'b1, w, z, l, ror(8'h02, 1'b0));
        run_op(long_op_t'(4'hb), 16'h0015, 8'hff, 1'b0, w, z, l, 8'h00);
        run_op(long_op_t'(4'hf), 16'h0016, 8'h00, 1'b0, w, z, l, 8'h00);
        go_idle();
    endtask

    // Reset in mid-run clears every output, then the block works again
    task automatic t_reset;
        i_rst_n = 1'b0;
        @(posedge i_mclk);
        @(negedge i_mclk);
        chk({o_mem_we, o_working, o_zero, o_link}, 16'h0000, "outputs in reset");
        chk(o_mem_addr, 16'h0000, "write address in reset");
        chk(o_mem_wdata, 8'h00, "write data in reset");
        i_rst_n = 1'b1;
        w = 8'h00;
        z = 1'b0;
        l = 1'b0;
        run_op(OP_COPY_TO_WORKING, 16'h0020, 8'h5a, 1'b0, 8'h5a, z, l, 8'h00);
        go_idle();
    endtask

    // ==========================================================
    // Verdict and main sequence
    task automatic give_verdict;
        if (failures == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (5) @(negedge i_mclk);
        i_rst_n = 1'b1;
        chk({o_mem_we, o_working, o_zero, o_link}, 16'h0000, "outputs after reset");
        chk(o_mem_addr, 16'h0000, "write address after reset");
        chk(o_mem_wdata, 8'h00, "write data after reset");
        t_or();
        t_rol();
        t_ror();
        t_flags_kept();
        t_reset();
        give_verdict();
    end
endmodule
